// >>> logic/sdcr_defines.svh
// Purpose: shared constants of the dual-channel register bank and its host
// Assumes: 13-bit register addresses, one data byte per serial frame
// Notes: masks give the bits a write passes through; zero mask means no write
`ifndef SDCR_DEFINES_SVH
`define SDCR_DEFINES_SVH
`define SDCR_AW         13
`define SDCR_A_CFG      13'h0000
`define SDCR_A_ID       13'h0001
`define SDCR_A_GRADE    13'h0002
`define SDCR_A_CHAN     13'h0005
`define SDCR_A_XFER     13'h00ff
`define SDCR_A_PWR      13'h0008
`define SDCR_A_CLK      13'h0009
`define SDCR_A_DIV      13'h000b
`define SDCR_A_TEST     13'h000d
`define SDCR_A_BIST     13'h000e
`define SDCR_A_VREF     13'h0018
`define SDCR_A_R30      13'h0030
`define SDCR_CFG_RST    8'h18
`define SDCR_CFG_MASK   8'h66
`define SDCR_CFG_SRST   8'h24
`define SDCR_CFG_LSB    8'h42
`define SDCR_CHAN_RST   8'h03
`define SDCR_CHAN_MASK  8'h03
`define SDCR_XFER_MASK  8'h01
`define SDCR_PWR_MASK   8'ha3
`define SDCR_PWR_RST    8'h80
`define SDCR_CLK_MASK   8'h01
`define SDCR_CLK_RST    8'h01
`define SDCR_DIV_MASK   8'h07
`define SDCR_DIV_RST    8'h00
`define SDCR_TEST_MASK  8'h3f
`define SDCR_TEST_RST   8'h00
`define SDCR_BIST_MASK  8'h05
`define SDCR_BIST_RST   8'h04
`define SDCR_VREF_MASK  8'hc0
`define SDCR_VREF_RST   8'hc0
`define SDCR_R30_MASK   8'hff
`define SDCR_R30_RST    8'h00
`define SDCR_NSHADOW    7
`define SDCR_NO_IDX     3'h7
`define SDCR_BYTE1_END  5'h08
`define SDCR_BYTE2_END  5'h10
`define SDCR_FRAME_END  5'h18
`define SDCR_HALF_DEF   2
`define SDCR_H_ADDR     4'h0
`define SDCR_H_WDATA    4'h4
`define SDCR_H_CMD      4'h8
`define SDCR_H_STATUS   4'hc
`endif

// >>> logic/sdcr_pkg.sv
// Purpose: types and address decoding shared by both ends
// Assumes: sdcr_defines.svh supplies every number
// Notes: shadow index order is the order of the active_cfg port
package sdcr_pkg;
`include "sdcr_defines.svh"
	typedef logic [7:0]            sdcr_byte_t;
	typedef logic [`SDCR_AW-1:0]   sdcr_addr_t;
	typedef enum logic [1:0]
	{
		HS_IDLE  = 2'b00,
		HS_SHIFT = 2'b01,
		HS_LAST  = 2'b10
	} sdcr_hstate_t;

	function automatic logic [2:0] sdcr_sidx(input sdcr_addr_t a);
		case (a)
			`SDCR_A_PWR:  return 3'h0;
			`SDCR_A_CLK:  return 3'h1;
			`SDCR_A_DIV:  return 3'h2;
			`SDCR_A_TEST: return 3'h3;
			`SDCR_A_BIST: return 3'h4;
			`SDCR_A_VREF: return 3'h5;
			`SDCR_A_R30:  return 3'h6;
			default:      return `SDCR_NO_IDX;
		endcase
	endfunction

	function automatic sdcr_byte_t sdcr_mask(input sdcr_addr_t a);
		case (a)
			`SDCR_A_CFG:  return `SDCR_CFG_MASK;
			`SDCR_A_CHAN: return `SDCR_CHAN_MASK;
			`SDCR_A_XFER: return `SDCR_XFER_MASK;
			`SDCR_A_PWR:  return `SDCR_PWR_MASK;
			`SDCR_A_CLK:  return `SDCR_CLK_MASK;
			`SDCR_A_DIV:  return `SDCR_DIV_MASK;
			`SDCR_A_TEST: return `SDCR_TEST_MASK;
			`SDCR_A_BIST: return `SDCR_BIST_MASK;
			`SDCR_A_VREF: return `SDCR_VREF_MASK;
			`SDCR_A_R30:  return `SDCR_R30_MASK;
			default:      return 8'h00;
		endcase
	endfunction

	function automatic sdcr_byte_t sdcr_dflt(input int i);
		case (i)
			0:       return `SDCR_PWR_RST;
			1:       return `SDCR_CLK_RST;
			2:       return `SDCR_DIV_RST;
			3:       return `SDCR_TEST_RST;
			4:       return `SDCR_BIST_RST;
			5:       return `SDCR_VREF_RST;
			default: return `SDCR_R30_RST;
		endcase
	endfunction

	function automatic logic sdcr_local(input sdcr_addr_t a);
		return (a == `SDCR_A_PWR) || (a == `SDCR_A_TEST);
	endfunction
endpackage

// >>> logic/sdcr_if.sv
// Purpose: three-wire serial link between host end and register bank
// Assumes: sdio idles high when neither end drives it
// Notes: the shared data line is resolved here from the two enables
`timescale 1ns/1ps
interface sdcr_if;
	logic   csb_n;
	logic   sclk;
	logic   sdio_h;
	logic   sdio_h_oe;
	logic   sdio_d;
	logic   sdio_d_oe;
	logic   sdio;
	assign sdio = sdio_h_oe ? sdio_h : (sdio_d_oe ? sdio_d : 1'b1);
	modport dev (input csb_n, input sclk, input sdio,
		output sdio_d, output sdio_d_oe);
	modport host (output csb_n, output sclk, output sdio_h,
		output sdio_h_oe, input sdio);
endinterface

// >>> logic/sdcr_shift.sv
// Purpose: one-byte shift register with selectable bit order
// Assumes: nothing of the caller; load takes priority over shift here
// Notes: after eight shifts data holds the byte in natural order
`timescale 1ns/1ps
module sdcr_shift
	import sdcr_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	input  wire logic  lsb_first,
	input  wire logic  load,
	input  sdcr_byte_t load_val,
	input  wire logic  shift_en,
	input  wire logic  bit_in,
	output sdcr_byte_t data,
	output logic       bit_out
);
	assign bit_out = lsb_first ? data[0] : data[7];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			data <= 8'h00;
		else if (ce && load)
			data <= load_val;
		else if (ce && shift_en)
			data <= lsb_first ? {bit_in, data[7:1]} : {data[6:0], bit_in};
	end
endmodule

// >>> logic/sdcr_device.sv
// Purpose: shadowed dual-channel configuration register bank, serial slave
// Assumes: sclk, csb_n and sdio synchronous to hclk; sclk half period >= 2
// Notes: one byte per frame; instruction byte 0 = {rw, 2'b00, addr[12:8]}
// Functional notes
// - unmapped addresses and bits do nothing
// - host writes zeros into open bits; the host writes ones into open bits 4 and 3 of the port config
// - host never writes fully open addresses
// - reset loads documented defaults
// - shadowed writes land in holding copy
// - writing one to transfer commits all
// - transfer bit clears itself after commit
// - local registers duplicated, chosen by channel index
// - both channels selected writes both copies
// - host selects one channel before reading
// - both selected read returns channel A
// - global registers ignore channel index
// - msb first until configured lsb first
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sdcr_defines.svh"
module sdcr_device
	import sdcr_pkg::*;
#(
	parameter sdcr_byte_t  ID_CODE = 8'h5a,
	parameter logic [1:0]  GRADE   = 2'b01,
	parameter int          NSH     = `SDCR_NSHADOW
)
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  ce,
	sdcr_if.dev                        sp,
	output logic [1:0][NSH-1:0][7:0]   active_cfg,
	output sdcr_byte_t                 port_cfg,
	output logic [1:0]                 chan_sel,
	output logic                       lsb_first,
	output logic                       commit_pulse,
	output logic                       dcs_on,
	output logic                       sdio_d,
	output logic                       sdio_d_oe
);
	// id code value is arbitrary
	logic [1:0][NSH-1:0][7:0]  hold;
	logic                      sclk_q;
	logic                      rise_q;
	logic [4:0]                bcnt;
	sdcr_byte_t                ins_hi;
	sdcr_addr_t                addr_q;
	logic                      xfer_pend;
	logic                      srst_pend;
	sdcr_byte_t                rx_byte;
	sdcr_byte_t                rd_data;
	logic                      tx_bit;

	wire        rise     = ~sp.csb_n & sp.sclk & ~sclk_q;
	wire        fall     = ~sp.csb_n & ~sp.sclk & sclk_q;
	wire        rd_op    = ins_hi[7];
	wire        at_addr  = rise_q & (bcnt == `SDCR_BYTE2_END);
	wire        wr_stb   = rise_q & (bcnt == `SDCR_FRAME_END) & ~rd_op;
	wire        tx_load  = at_addr & rd_op;
	wire        tx_shift = fall & rd_op & (bcnt >= `SDCR_BYTE2_END)
		& (bcnt < `SDCR_FRAME_END);
	wire sdcr_addr_t rd_addr = {ins_hi[4:0], rx_byte};
	wire [2:0]  rd_idx   = sdcr_sidx(rd_addr);
	// only B alone reads copy B; A alone, both, or none read copy A
	wire        rd_cp    = sdcr_local(rd_addr) & chan_sel[1] & ~chan_sel[0];
	wire sdcr_byte_t rd_hold = (rd_idx == `SDCR_NO_IDX) ? 8'h00
		: hold[rd_cp][rd_idx];
	wire [2:0]  wr_idx   = sdcr_sidx(addr_q);
	wire sdcr_byte_t wr_val = rx_byte & sdcr_mask(addr_q);
	// globals always live in copy A whatever the index says
	wire [1:0]  wr_cp    = sdcr_local(addr_q) ? chan_sel : 2'b01;
	wire        wr_shadow = wr_stb & (wr_idx != `SDCR_NO_IDX);
	wire        wr_cfg   = wr_stb & (addr_q == `SDCR_A_CFG);
	wire        wr_chan  = wr_stb & (addr_q == `SDCR_A_CHAN);
	wire        wr_xfer  = wr_stb & (addr_q == `SDCR_A_XFER);
	// divider ratio other than one forces the duty cycle stabilizer
	wire        next_dcs = active_cfg[0][1][0] | (active_cfg[0][2][2:0] != 3'h0);

	assign rd_data =
		(rd_addr == `SDCR_A_CFG)   ? port_cfg :
		(rd_addr == `SDCR_A_ID)    ? ID_CODE :
		(rd_addr == `SDCR_A_GRADE) ? {2'b00, GRADE, 4'h0} :
		(rd_addr == `SDCR_A_CHAN)  ? {6'h00, chan_sel} :
		(rd_addr == `SDCR_A_XFER)  ? {7'h00, xfer_pend} :
		rd_hold;

	sdcr_shift u_rx
	(
		.clk       (hclk),
		.rst_n     (hresetn),
		.ce        (ce),
		.lsb_first (lsb_first),
		.load      (1'b0),
		.load_val  (8'h00),
		.shift_en  (rise),
		.bit_in    (sp.sdio),
		.data      (rx_byte),
		.bit_out   ()
	);

	sdcr_shift u_tx
	(
		.clk       (hclk),
		.rst_n     (hresetn),
		.ce        (ce),
		.lsb_first (lsb_first),
		.load      (tx_load),
		.load_val  (rd_data),
		.shift_en  (tx_shift),
		.bit_in    (1'b0),
		.data      (),
		.bit_out   (tx_bit)
	);

	assign sp.sdio_d    = sdio_d;
	assign sp.sdio_d_oe = sdio_d_oe;

	// frame tracking; csb_n high aborts any partial frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sclk_q <= 1'b0;
			rise_q <= 1'b0;
			bcnt   <= 5'h00;
			ins_hi <= 8'h00;
			addr_q <= 13'h0000;
		end
		else if (ce)
		begin
			sclk_q <= sp.sclk;
			rise_q <= rise;
			if (sp.csb_n)
				bcnt <= 5'h00;
			else if (rise && bcnt != `SDCR_FRAME_END)
				bcnt <= bcnt + 5'h01;
			if (rise_q && bcnt == `SDCR_BYTE1_END)
				ins_hi <= rx_byte;
			if (at_addr)
				addr_q <= rd_addr;
		end
	end

	// read data goes out on falling sclk so it is settled at the next rise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sdio_d    <= 1'b0;
			sdio_d_oe <= 1'b0;
		end
		else if (ce && sp.csb_n)
			sdio_d_oe <= 1'b0;
		else if (ce && tx_shift)
		begin
			sdio_d    <= tx_bit;
			sdio_d_oe <= 1'b1;
		end
	end

	// global control registers; soft reset self-clears and reloads defaults
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_cfg  <= `SDCR_CFG_RST;
			chan_sel  <= 2'(`SDCR_CHAN_RST);
			xfer_pend <= 1'b0;
			srst_pend <= 1'b0;
		end
		else if (ce && srst_pend)
		begin
			port_cfg  <= `SDCR_CFG_RST;
			chan_sel  <= 2'(`SDCR_CHAN_RST);
			xfer_pend <= 1'b0;
			srst_pend <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_cfg)
				port_cfg <= (wr_val & ~`SDCR_CFG_SRST) | `SDCR_CFG_RST;
			srst_pend <= wr_cfg & ((wr_val & `SDCR_CFG_SRST) != 8'h00);
			if (wr_chan)
				chan_sel <= wr_val[1:0];
			// commit runs one cycle after the write, then the bit drops
			xfer_pend <= wr_xfer & wr_val[0];
		end
	end

	// holding and active copies
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int c = 0; c < 2; c++)
				for (int i = 0; i < NSH; i++)
				begin
					hold[c][i]       <= sdcr_dflt(i);
					active_cfg[c][i] <= sdcr_dflt(i);
				end
		end
		else if (ce && srst_pend)
		begin
			for (int c = 0; c < 2; c++)
				for (int i = 0; i < NSH; i++)
				begin
					hold[c][i]       <= sdcr_dflt(i);
					active_cfg[c][i] <= sdcr_dflt(i);
				end
		end
		else if (ce)
		begin
			if (xfer_pend)
				active_cfg <= hold;
			for (int c = 0; c < 2; c++)
				if (wr_shadow && wr_cp[c])
					hold[c][wr_idx] <= wr_val;
		end
	end

	// decoded status, registered so every output is a flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lsb_first    <= 1'b0;
			commit_pulse <= 1'b0;
			dcs_on       <= 1'b1;
		end
		else if (ce)
		begin
			lsb_first    <= (port_cfg & `SDCR_CFG_LSB) != 8'h00;
			commit_pulse <= xfer_pend;
			dcs_on       <= next_dcs;
		end
	end
endmodule

// >>> logic/sdcr_host.sv
// Purpose: AHB-Lite controlled serial master for the register bank
// Assumes: one slave, zero wait states; HALF of at least 2 hclk cycles
// Notes: refuses commands that would break the bank's usage rules
`timescale 1ns/1ps
`include "sdcr_defines.svh"
module sdcr_host
	import sdcr_pkg::*;
#(
	parameter logic [7:0] HALF = 8'(`SDCR_HALF_DEF)
)
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic [31:0]       hrdata,
	output logic              hresp,
	sdcr_if.host              sp,
	output logic              csb_n,
	output logic              sclk,
	output logic              sdio_h,
	output logic              sdio_h_oe
);
	sdcr_hstate_t  st;
	sdcr_addr_t    cmd_addr;
	sdcr_byte_t    cmd_wdata;
	sdcr_byte_t    rdata;
	sdcr_byte_t    b1;
	sdcr_byte_t    b2;
	sdcr_byte_t    sh_data;
	sdcr_byte_t    chan_trk;
	logic          lsb_trk;
	logic          busy;
	logic          refused;
	logic          rw;
	logic          rx_bit;
	logic          sh_bit;
	logic          dp_wr;
	logic [3:0]    dp_addr;
	logic [7:0]    div;
	logic [4:0]    fcnt;

	wire        ap_ok   = hsel & htrans[1] & hready;
	wire        cmd_stb = dp_wr & (dp_addr == `SDCR_H_CMD);
	wire        go_wr   = cmd_stb & hwdata[0];
	wire        go_rd   = cmd_stb & hwdata[1] & ~hwdata[0];
	wire sdcr_byte_t wmask = sdcr_mask(cmd_addr);
	wire        one_hot = chan_trk[0] ^ chan_trk[1];
	wire        bad_wr  = wmask == 8'h00;
	wire        bad_rd  = sdcr_local(cmd_addr) & ~one_hot;
	wire        start   = (st == HS_IDLE) & ((go_wr & ~bad_wr) | (go_rd & ~bad_rd));
	wire        refuse  = (go_wr | go_rd) & ~start;
	wire sdcr_byte_t wval = (cmd_wdata & wmask)
		| ((cmd_addr == `SDCR_A_CFG) ? `SDCR_CFG_RST : 8'h00);
	wire        tick    = (st != HS_IDLE) & (div == HALF - 8'h01);
	wire        fall_t  = (st == HS_SHIFT) & tick & sclk;
	wire        bnd     = (fcnt == 5'h07) | (fcnt == 5'h0f);
	wire        sh_load = start | (fall_t & bnd);
	wire sdcr_byte_t sh_val = start ? {go_rd, 2'b00, cmd_addr[12:8]}
		: (fcnt == 5'h07) ? b1 : b2;
	wire [31:0] rd_mux  = (haddr[3:0] == `SDCR_H_ADDR) ? {19'h0_0000, cmd_addr}
		: (haddr[3:0] == `SDCR_H_WDATA) ? {24'h00_0000, cmd_wdata}
		: (haddr[3:0] == `SDCR_H_STATUS) ? {16'h0000, rdata, 6'h00, refused, busy}
		: 32'h0000_0000;

	sdcr_shift u_sh
	(
		.clk       (hclk),
		.rst_n     (hresetn),
		.ce        (ce),
		.lsb_first (lsb_trk),
		.load      (sh_load),
		.load_val  (sh_val),
		.shift_en  (fall_t & ~bnd),
		.bit_in    (rx_bit),
		.data      (sh_data),
		.bit_out   (sh_bit)
	);

	assign sp.csb_n     = csb_n;
	assign sp.sclk      = sclk;
	assign sp.sdio_h    = sdio_h;
	assign sp.sdio_h_oe = sdio_h_oe;

	// AHB-Lite slave: always ready, always OKAY, reads registered
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			dp_wr     <= 1'b0;
			dp_addr   <= 4'h0;
			cmd_addr  <= 13'h0000;
			cmd_wdata <= 8'h00;
		end
		else if (ce)
		begin
			dp_wr   <= ap_ok & hwrite;
			dp_addr <= haddr[3:0];
			if (ap_ok && !hwrite)
				hrdata <= rd_mux;
			if (dp_wr && dp_addr == `SDCR_H_ADDR && !busy)
				cmd_addr <= hwdata[12:0];
			if (dp_wr && dp_addr == `SDCR_H_WDATA && !busy)
				cmd_wdata <= hwdata[7:0];
		end
	end

	// serial engine: data changes on falling sclk, samples on rising
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= HS_IDLE;
			{csb_n, sclk, sdio_h, sdio_h_oe} <= 4'h8;
			{busy, refused, rw, rx_bit, lsb_trk} <= 5'h00;
			{div, fcnt, b1, b2, rdata} <= 37'h0_0000_0000;
			chan_trk <= `SDCR_CHAN_RST;
		end
		else if (ce)
		begin
			sdio_h <= sh_bit;
			div    <= (tick || st == HS_IDLE) ? 8'h00 : div + 8'h01;
			if (refuse)
				refused <= 1'b1;
			else if (start)
				refused <= 1'b0;
			case (st)
				HS_IDLE:
					if (start)
					begin
						st <= HS_SHIFT;
						{csb_n, sdio_h_oe, busy, rw, fcnt} <= {3'h3, go_rd, 5'h00};
						b1 <= cmd_addr[7:0];
						b2 <= wval;
					end
				HS_SHIFT:
					if (tick && !sclk)
					begin
						sclk   <= 1'b1;
						rx_bit <= sp.sdio;
					end
					else if (tick)
					begin
						sclk <= 1'b0;
						fcnt <= fcnt + 5'h01;
						if (fcnt == 5'h0f && rw)
							sdio_h_oe <= 1'b0;
						if (fcnt == 5'h17)
							st <= HS_LAST;
					end
				HS_LAST:
					if (tick)
					begin
						st <= HS_IDLE;
						{csb_n, sdio_h_oe, busy} <= 3'h4;
						if (rw)
							rdata <= sh_data;
						if (!rw && cmd_addr == `SDCR_A_CHAN)
							chan_trk <= b2;
						if (!rw && cmd_addr == `SDCR_A_CFG)
							lsb_trk <= (b2 & `SDCR_CFG_LSB) != 8'h00;
						if (!rw && cmd_addr == `SDCR_A_CFG
							&& (b2 & `SDCR_CFG_SRST) != 8'h00)
						begin
							lsb_trk  <= 1'b0;
							chan_trk <= `SDCR_CHAN_RST;
						end
					end
				default:
					st <= HS_IDLE;
			endcase
		end
	end
endmodule

// >>> test/sdcr_link_props.sv
// Purpose: wire-level checks on the serial link between host and bank
// Assumes: one hclk domain, both ends driven from hclk flops
// Notes: HALF must match the host's sclk half period
`timescale 1ns/1ps
module sdcr_link_props
	import sdcr_pkg::*;
#(
	parameter logic [7:0] HALF = 8'h02
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic csb_n,
	input wire logic sclk,
	input wire logic sdio_h,
	input wire logic sdio_h_oe,
	input wire logic sdio_d,
	input wire logic sdio_d_oe,
	input wire logic sdio
);
	logic [7:0] hi_cnt;
	logic [5:0] rise_cnt;
	logic       sclk_q;

	// counts sampled sclk rises of the current frame
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hi_cnt   <= 8'h00;
			rise_cnt <= 6'h00;
			sclk_q   <= 1'b0;
		end
		else
		begin
			sclk_q   <= sclk;
			hi_cnt   <= sclk ? hi_cnt + 8'h01 : 8'h00;
			rise_cnt <= csb_n ? 6'h00 : rise_cnt + 6'(sclk & !sclk_q);
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_no_contention;
		!(sdio_h_oe && sdio_d_oe);
	endproperty
	a_no_contention: assert property (p_no_contention)
		else $error("both ends drive the data line");
	property p_dev_quiet;
		csb_n && $past(csb_n) |-> !sdio_d_oe;
	endproperty
	a_dev_quiet: assert property (p_dev_quiet)
		else $error("bank drives data line outside a frame");
	property p_sclk_idle;
		csb_n && $past(csb_n) |-> !sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock moves outside a frame");
	property p_high_len;
		$fell(sclk) |-> hi_cnt == HALF;
	endproperty
	a_high_len: assert property (p_high_len)
		else $error("serial clock high time wrong");
	property p_bit_count;
		$rose(csb_n) |-> rise_cnt == 6'h18;
	endproperty
	a_bit_count: assert property (p_bit_count)
		else $error("frame does not hold 24 bits");
	property p_turnaround;
		$rose(sdio_d_oe) |-> rise_cnt == 6'h10 && !csb_n;
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("bank turns the line at the wrong bit");
	property p_frame_start;
		$fell(csb_n) |-> sdio_h_oe && !sclk ##1 !sclk ##[1:8] sclk;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("frame start sequence wrong");
	property p_stable_high;
		sclk && $past(sclk) |-> $stable(sdio);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data moves while serial clock high");
endmodule

// >>> test/shadowed_dual_channel_regbank_test.sv
// Purpose: end-to-end test of host and bank over AHB-Lite
// Assumes: HALF of 2, two channel copies per local register
// Notes: model keeps holding, active and channel state
`timescale 1ns/1ps
`include "sdcr_defines.svh"
module shadowed_dual_channel_regbank_test
	import sdcr_pkg::*;
;
	logic                  hclk = 1'b0;
	logic                  hresetn = 1'b0;
	logic                  hsel = 1'b0;
	logic [31:0]           haddr = 32'h0000_0000;
	logic [1:0]            htrans = 2'b00;
	logic                  hwrite = 1'b0;
	logic [2:0]            hsize = 3'h2;
	logic [31:0]           hwdata = 32'h0000_0000;
	logic                  hrdy;
	logic [31:0]           hrdata;
	logic [1:0][6:0][7:0]  act;
	logic [7:0]            port_cfg;
	logic [1:0]            chan_sel;
	logic                  lsb_first;
	logic                  commit_pulse;
	logic                  dcs_on;
	logic                  hresp;
	logic                  cseen = 1'b0;
	logic                  sq = 1'b0;
	logic                  mlsb;
	logic [23:0]           fb = 24'h00_0000;
	int                    errors = 0;
	int                    num_checks = 0;
	int                    mch;
	int                    mh[2][7];
	int                    ma[2][7];
	int sa[7] = '{`SDCR_A_PWR, `SDCR_A_CLK, `SDCR_A_DIV, `SDCR_A_TEST,
		`SDCR_A_BIST, `SDCR_A_VREF, `SDCR_A_R30};
	int sm[7] = '{`SDCR_PWR_MASK, `SDCR_CLK_MASK, `SDCR_DIV_MASK,
		`SDCR_TEST_MASK, `SDCR_BIST_MASK, `SDCR_VREF_MASK, `SDCR_R30_MASK};
	int sd[7] = '{`SDCR_PWR_RST, `SDCR_CLK_RST, `SDCR_DIV_RST,
		`SDCR_TEST_RST, `SDCR_BIST_RST, `SDCR_VREF_RST, `SDCR_R30_RST};

	sdcr_if u_sdcr_if();
	sdcr_host #(.HALF(8'h02)) u_sdcr_host (.hclk(hclk), .hresetn(hresetn),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .sp(u_sdcr_if),
		.csb_n(), .sclk(), .sdio_h(), .sdio_h_oe());
	sdcr_device u_sdcr_device (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.sp(u_sdcr_if), .active_cfg(act), .port_cfg(port_cfg),
		.chan_sel(chan_sel), .lsb_first(lsb_first),
		.commit_pulse(commit_pulse), .dcs_on(dcs_on), .sdio_d(),
		.sdio_d_oe());
	sdcr_link_props #(.HALF(8'h02)) u_sdcr_link_props (.hclk(hclk),
		.hresetn(hresetn), .csb_n(u_sdcr_if.csb_n), .sclk(u_sdcr_if.sclk),
		.sdio_h(u_sdcr_if.sdio_h), .sdio_h_oe(u_sdcr_if.sdio_h_oe),
		.sdio_d(u_sdcr_if.sdio_d), .sdio_d_oe(u_sdcr_if.sdio_d_oe),
		.sdio(u_sdcr_if.sdio));

	always #25 hclk = ~hclk;

	// bits as the bank samples them, one per sclk rise
	always @(posedge hclk)
	begin
		if (u_sdcr_if.sclk && !sq && !u_sdcr_if.csb_n)
			fb = {fb[22:0], u_sdcr_if.sdio};
		sq = u_sdcr_if.sclk;
		if (commit_pulse === 1'b1)
			cseen = 1'b1;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	function automatic logic [7:0] rev8(input logic [7:0] x);
		for (int i = 0; i < 8; i++) rev8[i] = x[7-i];
	endfunction

	function automatic int fidx(input int a);
		for (int i = 0; i < 7; i++) if (sa[i] == a) return i;
		return 7;
	endfunction

	function automatic int mexp(input int a);
		int i;
		i = fidx(a);
		if (a == 0) return mlsb ? 8'h5a : 8'h18;
		if (a == `SDCR_A_CHAN) return mch;
		if (i == 7) return 0;
		return (mch == 2 && (i == 0 || i == 3)) ? mh[1][i] : mh[0][i];
	endfunction

	task automatic frame(input int a, input int d, input logic r,
		output logic [7:0] q);
		logic [31:0] s;
		logic [23:0] w;
		int n;
		ahb(1'b1, `SDCR_H_ADDR, a, s);
		ahb(1'b1, `SDCR_H_WDATA, d, s);
		ahb(1'b1, `SDCR_H_CMD, r ? 2 : 1, s);
		n = 0;
		do
		begin
			ahb(1'b0, `SDCR_H_STATUS, 0, s);
			n++;
		end
		while (s[0] && n < 400);
		errors += (n >= 400);
		q = s[15:8];
		// bits 4 and 3 of the port config always go out as ones
		w = {r, 7'h00, a[7:0],
			d[7:0] | ((a == `SDCR_A_CFG) ? `SDCR_CFG_RST : 8'h00)};
		if (mlsb) w = {rev8(w[23:16]), rev8(w[15:8]), rev8(w[7:0])};
		chk(fb, w);
	endtask

	task automatic mreset;
		mch = 3;
		mlsb = 1'b0;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 7; i++) mh[c][i] = sd[i];
		ma = mh;
	endtask

	task automatic wr(input int a, input int d);
		logic [7:0] q;
		int i;
		int n;
		i = fidx(a);
		cseen = 1'b0;
		frame(a, d, 1'b0, q);
		if (a == `SDCR_A_CHAN) mch = d;
		for (int c = 0; c < 2; c++)
			if (i < 7 && ((i == 0 || i == 3) ? mch[c] : c == 0)) mh[c][i] = d;
		if (a == 0) mlsb = (d & 8'h42) != 0;
		if (a == 0 && (d & 8'h24) != 0) mreset();
		if (a == `SDCR_A_XFER)
		begin
			n = 0;
			while (!cseen && n < 50)
			begin
				@(posedge hclk);
				n++;
			end
			chk(cseen, 1'h1);
			ma = mh;
		end
	endtask

	task automatic rd(input int a);
		logic [7:0] q;
		int e;
		e = mexp(a);
		frame(a, e, 1'b1, q);
		chk(q, e);
	endtask

	task automatic refuse(input int a, input int cmd);
		logic [31:0] s;
		ahb(1'b1, `SDCR_H_ADDR, a, s);
		ahb(1'b1, `SDCR_H_CMD, cmd, s);
		ahb(1'b0, `SDCR_H_STATUS, 0, s);
		chk(s[1:0], 2'h2);
		chk(hresp, 1'b0);
	endtask

	task automatic chkact;
		for (int c = 0; c < 2; c++)
			for (int i = 0; i < 7; i++) chk(act[c][i], ma[c][i]);
		chk(dcs_on, (ma[0][1] & 1) | ((ma[0][2] & 7) != 0));
	endtask

	initial
	begin
		#2_000_000;
		errors++;
		test_done();
	end

	initial
	begin
		void'($urandom(32'h4b47));
		mreset();
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chkact();
		chk(port_cfg, 8'h18);
		chk(chan_sel, 2'h3);
		rd(0);
		rd(`SDCR_A_CHAN);
		rd(13'h0013);
		refuse(13'h0013, 1);
		refuse(`SDCR_A_PWR, 2);
		// channel A, then B, then both; bench keeps open bits at zero
		for (int k = 1; k < 4; k++)
		begin
			wr(`SDCR_A_CHAN, k);
			for (int i = 0; i < 7; i++) wr(sa[i], $urandom & sm[i]);
			chkact();
			if (k < 3)
				for (int i = 0; i < 7; i++) rd(sa[i]);
			wr(`SDCR_A_XFER, 1);
			chkact();
			rd(`SDCR_A_XFER);
		end
		wr(0, 8'h42);
		chk(lsb_first, 1'h1);
		chk(port_cfg, 8'h5a);
		wr(`SDCR_A_CHAN, 2);
		rd(0);
		rd(`SDCR_A_PWR);
		wr(0, 8'h18);
		chk(lsb_first, 1'h0);
		wr(`SDCR_A_VREF, 8'h40);
		wr(`SDCR_A_XFER, 1);
		wr(0, 8'h24);
		chkact();
		chk(chan_sel, 2'h3);
		wr(`SDCR_A_CHAN, 1);
		wr(`SDCR_A_DIV, 8'h05);
		wr(`SDCR_A_XFER, 1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		mreset();
		chkact();
		test_done();
	end
endmodule
